// File: inc/ident_pkg.sv
// Package: identify-word indices, fixed word values, field positions and structs
package ident_pkg;
  // Word indices inside the 256-word identify block
  localparam logic [7:0] W_CAPS = 8'h31;
  localparam logic [7:0] W_PIO_MODE = 8'h33;
  localparam logic [7:0] W_XLAT_VALID = 8'h35;
  localparam logic [7:0] W_CUR_CYL = 8'h36;
  localparam logic [7:0] W_CUR_HEAD = 8'h37;
  localparam logic [7:0] W_CUR_SPT = 8'h38;
  localparam logic [7:0] W_CUR_CAP_LO = 8'h39;
  localparam logic [7:0] W_CUR_CAP_HI = 8'h3A;
  localparam logic [7:0] W_MULT_SET = 8'h3B;
  localparam logic [7:0] W_LBA_LO = 8'h3C;
  localparam logic [7:0] W_LBA_HI = 8'h3D;
  localparam logic [7:0] W_MWDMA = 8'h3F;
  localparam logic [7:0] W_ADV_PIO = 8'h40;
  localparam logic [7:0] W_DMA_MIN = 8'h41;
  localparam logic [7:0] W_DMA_REC = 8'h42;
  localparam logic [7:0] W_PIO_NOFC = 8'h43;
  localparam logic [7:0] W_PIO_FC = 8'h44;
  localparam logic [7:0] W_MAJOR = 8'h50;
  localparam logic [7:0] W_MINOR = 8'h51;
  localparam logic [7:0] W_FEAT = 8'h52;
  localparam logic [7:0] W_LAST = 8'hFF;
  // Capabilities word bit positions
  localparam int CAP_STANDBY_BIT = 13;
  localparam int CAP_IORDY_BIT = 11;
  localparam int CAP_LBA_BIT = 9;
  localparam int CAP_DMA_BIT = 8;
  // Fixed values
  localparam logic [15:0] PIO_MODE_VAL = 16'h0200;
  localparam logic [15:0] XLAT_VALID_VAL = 16'h0007;
  localparam logic [7:0] MULT_VALID_BYTE = 8'h01;
  localparam logic [7:0] MULT_RESET = 8'h00;
  localparam logic [2:0] MWDMA_SUPPORTED = 3'h7;
  localparam logic [2:0] MWDMA_SEL_RESET = 3'h0;
  localparam logic [7:0] ADV_PIO_VAL = 8'h03;
  localparam int DMA_CYCLE_NS = 120;
  localparam int PIO_CYCLE_NS = 120;
  localparam logic [15:0] DMA_CYCLE_WORD = 16'h0078;
  localparam logic [15:0] PIO_CYCLE_WORD = 16'h0078;
  localparam logic [15:0] MAJOR_VAL = 16'h007E;
  localparam logic [15:0] MINOR_VAL = 16'h0019;
  localparam logic [15:0] FEAT_VAL = 16'h706B;
  localparam int CLK_NS = 10;
  // Recommended DMA word time in clocks, rounded up
  localparam int DMA_REC_CYC = (DMA_CYCLE_NS + CLK_NS - 1) / CLK_NS;

  // Current geometry as set by firmware
  typedef struct packed {
    logic [15:0] cyl;
    logic [15:0] heads;
    logic [15:0] spt;
  } geom_t;

  // Settings commands from the command decoder
  typedef struct packed {
    logic multSet;
    logic [7:0] multCount;
    logic dmaSet;
    logic [1:0] dmaMode;
  } setcmd_t;
endpackage

// File: logic/ata_identify_capability_words.sv
// Identify-data word generator for capability and configuration words 49..82
//
// Functional notes
// - Capabilities bit 13 reads 0: device forces sleep itself.
// - Capabilities bits 11, 9, 8 read 1: IORDY, LBA, DMA.
// - PIO timing mode word reports PIO mode 2 (0200H).
// - Translation-valid bit 0 is 1: words 54..58 valid.
// - Translation-valid bits 1 and 2 are 1: words 64..70 and 88 valid.
// - Words 54..56 give current cylinders, heads, sectors per track.
// - Words 57..58 give product of current cylinders, heads, sectors.
// - Multiple-sector word upper byte is fixed 01H.
// - Multiple-sector lower byte holds last Set Multiple count, resets 00H.
// - Words 60..61 give total LBA-addressable sectors.
// - Multi-word DMA selected bits 10..8 are one-hot or all clear.
// - DMA supported bits 2..0 set; reserved bits read zero.
// - Advanced PIO bits 1..0 set, bits 7..2 zero.
// - Minimum and recommended DMA cycle words report 120 ns.
// - Host faster than recommended may see DMARQ paused.
// - Minimum PIO cycle without IORDY reports 0078H.
// - Minimum PIO cycle with IORDY reports 0078H.
// - Major version word sets bits 6..1 for ATA-1..ATA-6.
// - Minor version word reports 0019H.
// - Features-supported word reports 706BH.
// - Unsupported and obsolete feature bits read zero.
`timescale 1ns/10ps
module ata_identify_capability_words (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Firmware-supplied drive configuration
  input wire ident_pkg::geom_t curGeom,
  input wire logic [31:0] lbaSectors,
  // Settings commands
  input wire ident_pkg::setcmd_t setCmd,
  // Identify read port
  input wire logic rdStb,
  input wire logic [7:0] rdWord,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic inWindow,
  // DMA pacing
  input wire logic dmaWordStb,
  output logic dmaPause,
  // Current DMA mode selection view
  output logic [2:0] dmaSelected
);
  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  logic [7:0] multCount_ff;
  logic [2:0] dmaSel_ff;
  logic [2:0] nxt_dmaSel;
  logic [15:0] rdData_ff;
  logic rdValid_ff;
  logic [31:0] curCap;

  // Selecting one mode clears the others; mode 3 is not offered and is ignored
  assign nxt_dmaSel = (setCmd.dmaMode == 2'h3) ? dmaSel_ff
                    : 3'(3'h1 << setCmd.dmaMode);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      multCount_ff <= ident_pkg::MULT_RESET;
      dmaSel_ff <= ident_pkg::MWDMA_SEL_RESET;
    end else begin
      if (setCmd.multSet) multCount_ff <= setCmd.multCount;
      if (setCmd.dmaSet) dmaSel_ff <= nxt_dmaSel;
    end
  end

  assign dmaSelected = dmaSel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  geom_capacity capCalc (
    .mclk(mclk),
    .rst_n(rst_n),
    .geom(curGeom),
    .capacity(curCap)
  );

  dma_pace pacer (
    .mclk(mclk),
    .rst_n(rst_n),
    .wordStb(dmaWordStb),
    .pause(dmaPause)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fixed word images
  wire [15:0] capsWord = (16'h0001 << ident_pkg::CAP_IORDY_BIT)
                       | (16'h0001 << ident_pkg::CAP_LBA_BIT)
                       | (16'h0001 << ident_pkg::CAP_DMA_BIT);
  wire [15:0] multWord = {ident_pkg::MULT_VALID_BYTE, multCount_ff};
  wire [15:0] mwdmaWord = {5'h00, dmaSel_ff, 5'h00,
                           ident_pkg::MWDMA_SUPPORTED};
  wire [15:0] advPioWord = {8'h00, ident_pkg::ADV_PIO_VAL};

  ////////////////////////////////////////////////////////////////////////////
  // Word selection; words outside this range belong to other blocks
  logic [15:0] wordMux;
  assign inWindow = (rdWord >= ident_pkg::W_CAPS) && (rdWord <= ident_pkg::W_FEAT);

  always_comb begin
    unique case (rdWord)
      ident_pkg::W_CAPS: wordMux = capsWord;
      ident_pkg::W_PIO_MODE: wordMux = ident_pkg::PIO_MODE_VAL;
      ident_pkg::W_XLAT_VALID: wordMux = ident_pkg::XLAT_VALID_VAL;
      ident_pkg::W_CUR_CYL: wordMux = curGeom.cyl;
      ident_pkg::W_CUR_HEAD: wordMux = curGeom.heads;
      ident_pkg::W_CUR_SPT: wordMux = curGeom.spt;
      ident_pkg::W_CUR_CAP_LO: wordMux = curCap[15:0];
      ident_pkg::W_CUR_CAP_HI: wordMux = curCap[31:16];
      ident_pkg::W_MULT_SET: wordMux = multWord;
      ident_pkg::W_LBA_LO: wordMux = lbaSectors[15:0];
      ident_pkg::W_LBA_HI: wordMux = lbaSectors[31:16];
      ident_pkg::W_MWDMA: wordMux = mwdmaWord;
      ident_pkg::W_ADV_PIO: wordMux = advPioWord;
      ident_pkg::W_DMA_MIN: wordMux = ident_pkg::DMA_CYCLE_WORD;
      ident_pkg::W_DMA_REC: wordMux = ident_pkg::DMA_CYCLE_WORD;
      ident_pkg::W_PIO_NOFC: wordMux = ident_pkg::PIO_CYCLE_WORD;
      ident_pkg::W_PIO_FC: wordMux = ident_pkg::PIO_CYCLE_WORD;
      ident_pkg::W_MAJOR: wordMux = ident_pkg::MAJOR_VAL;
      ident_pkg::W_MINOR: wordMux = ident_pkg::MINOR_VAL;
      ident_pkg::W_FEAT: wordMux = ident_pkg::FEAT_VAL;
      default: wordMux = 16'h0000;
    endcase
  end

  // One-cycle registered answer per read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 16'h0000;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= rdStb;
      if (rdStb) rdData_ff <= wordMux;
    end
  end

  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  caps_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CAPS |=> rdData[13] == 1'b0) else $error("standby bit set");
  caps_support_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CAPS |=> rdData[11] && rdData[9] && rdData[8])
    else $error("caps support bits");
  pio_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_PIO_MODE |=> rdData == 16'h0200) else $error("pio mode");
  xlat_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_XLAT_VALID |=> rdData[2:0] == 3'h7)
    else $error("translation valid");
  xlat_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_XLAT_VALID |=> rdData[2] && rdData[1])
    else $error("words 64 or 88 invalid");
  geom_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CUR_HEAD |=> rdData == $past(curGeom.heads))
    else $error("heads mismatch");
  mult_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MULT_SET |=> rdData == {8'h01, $past(multCount_ff)})
    else $error("multiple word");
  mult_update_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setCmd.multSet |=> multCount_ff == $past(setCmd.multCount))
    else $error("multiple count not stored");
  lba_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_LBA_HI |=> rdData == $past(lbaSectors[31:16]))
    else $error("lba high");
  dma_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot0(dmaSel_ff)) else $error("dma select not one-hot");
  dma_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setCmd.dmaSet && setCmd.dmaMode == 2'h2 |=> dmaSel_ff == 3'h4)
    else $error("mode 2 not selected");
  mwdma_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MWDMA |=> rdData[2:0] == 3'h7
    && rdData[15:11] == 5'h00 && rdData[7:3] == 5'h00) else $error("mwdma word");
  adv_pio_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_ADV_PIO |=> rdData == 16'h0003) else $error("adv pio");
  dma_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && (rdWord == ident_pkg::W_DMA_MIN || rdWord == ident_pkg::W_DMA_REC)
    |=> rdData == 16'h0078) else $error("dma cycle");
  pio_nofc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_PIO_NOFC |=> rdData == 16'h0078) else $error("pio nofc");
  pio_iordy_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_PIO_FC |=> rdData == 16'h0078) else $error("pio iordy");
  major_ver_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MAJOR |=> rdData == 16'h007E) else $error("major");
  minor_ver_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MINOR |=> rdData == 16'h0019) else $error("minor");
  feat_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_FEAT |=> rdData == 16'h706B
    && (rdData & 16'h8F94) == 16'h0000) else $error("features");
  read_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb |=> rdValid) else $error("no answer to read");

  ////////////////////////////////////////////////////////////////////////////
  // Whole-word checks per identify word, byte checks and hold of the multiple-sector word
  caps_exact_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CAPS
    |=> rdData == 16'h0B00)
    else $error("capabilities word");

  xlat_exact_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_XLAT_VALID
    |=> rdData == 16'h0007)
    else $error("translation word");

  cyl_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CUR_CYL
    |=> rdData == $past(curGeom.cyl))
    else $error("cylinders mismatch");

  spt_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CUR_SPT
    |=> rdData == $past(curGeom.spt))
    else $error("sectors per track mismatch");

  cap_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CUR_CAP_LO
    |=> rdData == $past(curCap[15:0]))
    else $error("capacity low word");

  cap_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_CUR_CAP_HI
    |=> rdData == $past(curCap[31:16]))
    else $error("capacity high word");

  lba_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_LBA_LO
    |=> rdData == $past(lbaSectors[15:0]))
    else $error("lba low");

  mult_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MULT_SET
    |=> rdData[15:8] == 8'h01)
    else $error("multiple valid byte");

  mult_lower_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MULT_SET
    |=> rdData[7:0] == $past(multCount_ff))
    else $error("multiple count byte");

  mult_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !setCmd.multSet
    |=> multCount_ff == $past(multCount_ff))
    else $error("multiple count drifted");

  ////////////////////////////////////////////////////////////////////////////
  // Multi-word DMA selection
  mwdma_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MWDMA
    |=> rdData[10:8] == $past(dmaSel_ff))
    else $error("selected bits not shown");

  mwdma_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MWDMA
    |=> $onehot0(rdData[10:8]))
    else $error("selected bits not one-hot");

  dma_mode0_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setCmd.dmaSet && setCmd.dmaMode == 2'h0
    |=> dmaSel_ff == 3'h1)
    else $error("mode 0 not selected");

  dma_mode1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setCmd.dmaSet && setCmd.dmaMode == 2'h1
    |=> dmaSel_ff == 3'h2)
    else $error("mode 1 not selected");

  dma_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
    setCmd.dmaSet && setCmd.dmaMode == 2'h3
    |=> dmaSel_ff == $past(dmaSel_ff))
    else $error("unoffered mode changed selection");

  dma_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !setCmd.dmaSet
    |=> dmaSel_ff == $past(dmaSel_ff))
    else $error("selection drifted");

  dma_view_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1
    |-> dmaSelected == dmaSel_ff)
    else $error("selection view differs");

  ////////////////////////////////////////////////////////////////////////////
  // Timing, version and feature words
  adv_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_ADV_PIO
    |=> rdData[15:2] == 14'h0000)
    else $error("advanced pio reserved bits");

  dma_min_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_DMA_MIN
    |=> rdData == 16'h0078)
    else $error("minimum dma cycle");

  dma_rec_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_DMA_REC
    |=> rdData == 16'h0078)
    else $error("recommended dma cycle");

  major_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MAJOR
    |=> rdData[6:1] == 6'h3F && rdData != 16'hFFFF)
    else $error("major version bits");

  minor_reported_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_MINOR
    |=> rdData != 16'h0000 && rdData != 16'hFFFF)
    else $error("minor version unreported");

  feat_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_FEAT
    |=> (rdData & 16'h706B) == 16'h706B)
    else $error("supported feature bit clear");

  feat_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == ident_pkg::W_FEAT
    |=> (rdData & 16'h8F94) == 16'h0000)
    else $error("unsupported feature bit set");

  ////////////////////////////////////////////////////////////////////////////
  // Reserved and foreign words, read port behaviour
  resv_fifty_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == 8'h32
    |=> rdData == 16'h0000)
    else $error("word 50 not zero");

  resv_fiftytwo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == 8'h34
    |=> rdData == 16'h0000)
    else $error("word 52 not zero");

  resv_sixtytwo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord == 8'h3E
    |=> rdData == 16'h0000)
    else $error("word 62 not zero");

  resv_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && rdWord >= 8'h45 && rdWord <= 8'h4F
    |=> rdData == 16'h0000)
    else $error("reserved block not zero");

  outside_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rdStb && !inWindow
    |=> rdData == 16'h0000)
    else $error("foreign word not zero");

  valid_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rdStb
    |=> !rdValid)
    else $error("answer without read");

  data_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rdStb
    |=> $stable(rdData))
    else $error("read data changed without read");

  ////////////////////////////////////////////////////////////////////////////
  // DMA flow control
  pause_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dmaPause
    |-> $past(dmaWordStb))
    else $error("pause without word");

  no_pause_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !dmaWordStb
    |=> !dmaPause)
    else $error("pause while idle");
endmodule

// File: logic/dma_pace.sv
// Measures host DMA word spacing and asks for a DMARQ pause when too fast
`timescale 1ns/10ps
module dma_pace #(
  parameter int REC_CYC = ident_pkg::DMA_REC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Word strobe from the data port, pause request out
  input wire logic wordStb,
  output logic pause
);
  initial begin
    if (REC_CYC < 2 || REC_CYC > 255) $error("REC_CYC out of range");
  end
  logic [7:0] gap_ff;
  logic pause_ff;
  logic tooFast;

  assign tooFast = wordStb && (gap_ff < 8'(REC_CYC));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 8'hFF;
      pause_ff <= 1'b0;
    end else begin
      // Count from one so a word exactly REC_CYC clocks after the last is not too fast
      if (wordStb) gap_ff <= 8'h01;
      else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
      pause_ff <= tooFast;
    end
  end

  assign pause = pause_ff;

  pause_on_fast_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tooFast |=> pause) else $error("no pause after fast word");
endmodule

// File: logic/geom_capacity.sv
// Registered capacity product of cylinders, heads and sectors per track
`timescale 1ns/10ps
module geom_capacity (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Geometry in, product out
  input wire ident_pkg::geom_t geom,
  output logic [31:0] capacity
);
  logic [31:0] chsProd;
  logic [31:0] capacity_ff;

  // Product truncated to the 32-bit field; real geometry never exceeds it
  // Widen each factor first: a cast around the product would multiply at 16 bits
  assign chsProd = 32'(geom.cyl) * 32'(geom.heads) * 32'(geom.spt);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) capacity_ff <= 32'h0000_0000;
    else capacity_ff <= chsProd;
  end

  assign capacity = capacity_ff;

  capacity_tracks_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> capacity == $past(chsProd)) else $error("capacity not product");
endmodule

// File: tb/ata_identify_capability_words_tb_top.sv
// Self-checking bench for the identify capability word generator
`timescale 1ns/10ps
module ata_identify_capability_words_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  ident_pkg::geom_t curGeom = '0;
  logic [31:0] lbaSectors = 32'h0;
  ident_pkg::setcmd_t setCmd = '0;
  logic rdStb, rdValid, inWindow, dmaWordStb, dmaPause;
  logic [7:0] rdWord;
  logic [15:0] rdData;
  logic [2:0] dmaSelected;
  int failures = 0;
  int checked = 0;
  logic [7:0] fixIdx [18] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3E, 8'h40, 8'h41,
    8'h42, 8'h43, 8'h44, 8'h45, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53};
  logic [15:0] fixVal [18] = '{16'h0000, 16'h0B00, 16'h0000, 16'h0200, 16'h0000, 16'h0007,
    16'h0000, 16'h0003, 16'h0078, 16'h0078, 16'h0078, 16'h0078, 16'h0000, 16'h0000,
    16'h007E, 16'h0019, 16'h706B, 16'h0000};

  always #5 mclk = ~mclk;

  ata_identify_capability_words ata_identify_capability_words_inst (
    .mclk(mclk), .rst_n(rst_n), .curGeom(curGeom), .lbaSectors(lbaSectors),
    .setCmd(setCmd), .rdStb(rdStb), .rdWord(rdWord), .rdData(rdData), .rdValid(rdValid),
    .inWindow(inWindow), .dmaWordStb(dmaWordStb), .dmaPause(dmaPause),
    .dmaSelected(dmaSelected)
  );
  ident_host_model ident_host_model_inst (
    .mclk(mclk), .rdStb(rdStb), .rdWord(rdWord), .rdData(rdData), .rdValid(rdValid),
    .inWindow(inWindow), .dmaWordStb(dmaWordStb), .dmaPause(dmaPause)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    logic vl;
    logic w;
    ident_host_model_inst.readWord(idx, v, vl, w);
    check({15'h0000, vl}, 16'h0001);
    check({15'h0000, w}, {15'h0000, (idx >= 8'h31 && idx <= 8'h52)});
    check(v, exp);
  endtask
  task automatic setPulse(input ident_pkg::setcmd_t cmd);
    @(negedge mclk);
    setCmd = cmd;
    @(negedge mclk);
    setCmd = '0;
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fixed;
    for (int i = 0; i < 18; i++) begin
      rd(fixIdx[i], fixVal[i]);
    end
    $display("test fixed done");
  endtask
  // Product above 16 bits so the capacity high word carries data; the low word is zero
  task automatic t_geom;
    @(negedge mclk);
    curGeom = '{cyl: 16'h1000, heads: 16'h0010, spt: 16'h003F};
    lbaSectors = 32'h1234_5678;
    rd(8'h36, 16'h1000);
    rd(8'h37, 16'h0010);
    rd(8'h38, 16'h003F);
    rd(8'h39, 16'h0000);
    rd(8'h3A, 16'h003F);
    rd(8'h3C, 16'h5678);
    rd(8'h3D, 16'h1234);
    $display("test geometry done");
  endtask
  task automatic t_mult;
    rd(8'h3B, 16'h0100);
    setPulse('{multSet: 1'b1, multCount: 8'h10, dmaSet: 1'b0, dmaMode: 2'h0});
    rd(8'h3B, 16'h0110);
    setPulse('{multSet: 1'b1, multCount: 8'hFF, dmaSet: 1'b0, dmaMode: 2'h0});
    rd(8'h3B, 16'h01FF);
    $display("test multiple done");
  endtask
  task automatic t_dma;
    logic [2:0] sel;
    rd(8'h3F, 16'h0007);
    for (int m = 0; m < 3; m++) begin
      sel = 3'h1 << m;
      setPulse('{multSet: 1'b0, multCount: 8'h00, dmaSet: 1'b1, dmaMode: m[1:0]});
      check({13'h0000, dmaSelected}, {13'h0000, sel});
      rd(8'h3F, {5'h00, sel, 8'h07});
    end
    setPulse('{multSet: 1'b0, multCount: 8'h00, dmaSet: 1'b1, dmaMode: 2'h3});
    rd(8'h3F, 16'h0407);
    $display("test dma mode done");
  endtask
  // Spacing of 12 cycles is just slow enough; 11 and 2 are too fast
  task automatic t_pace;
    logic p;
    ident_host_model_inst.pulseWord(0, p);
    ident_host_model_inst.pulseWord(10, p);
    check({15'h0000, p}, 16'h0000);
    ident_host_model_inst.pulseWord(9, p);
    check({15'h0000, p}, 16'h0001);
    ident_host_model_inst.pulseWord(0, p);
    check({15'h0000, p}, 16'h0001);
    check(ident_host_model_inst.pauseCount[15:0], 16'h0002);
    $display("test pacing done");
  endtask
  // Mid-run reset must drop settings back to their defaults
  task automatic t_reset;
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check({13'h0000, dmaSelected}, 16'h0000);
    rst_n = 1'b1;
    rd(8'h3B, 16'h0100);
    rd(8'h3F, 16'h0007);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    t_fixed();
    t_geom();
    t_mult();
    t_dma();
    t_pace();
    t_reset();
    stop_test();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule

// File: tb/ident_host_model.sv
// Host model that reads identify words and strobes DMA words
`timescale 1ns/10ps
module ident_host_model (
  // Clock
  input wire logic mclk,
  // Identify read port
  output logic rdStb,
  output logic [7:0] rdWord,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic inWindow,
  // DMA pacing
  output logic dmaWordStb,
  input wire logic dmaPause
);
  int pauseCount;
  initial begin
    rdStb = 1'b0;
    rdWord = 8'h00;
    dmaWordStb = 1'b0;
    pauseCount = 0;
  end
  // One word per request; the answer is taken one cycle after the request edge
  task automatic readWord(input logic [7:0] idx, output logic [15:0] val, output logic vld,
    output logic win);
    @(negedge mclk);
    rdStb = 1'b1;
    rdWord = idx;
    #1 win = inWindow;
    @(negedge mclk);
    rdStb = 1'b0;
    rdWord = ~idx;
    vld = rdValid;
    val = rdData;
  endtask
  // Pauses are only counted: a host must ride them out
  task automatic pulseWord(input int idle, output logic paused);
    repeat (idle) @(negedge mclk);
    @(negedge mclk);
    dmaWordStb = 1'b1;
    @(negedge mclk);
    dmaWordStb = 1'b0;
    paused = dmaPause;
    if (paused === 1'b1) pauseCount++;
  endtask
endmodule
